// [common/fsw_regs.svh]
`ifndef FSW_REGS_SVH
`define FSW_REGS_SVH
// register byte offsets on the apb slave
`define FSW_CMD_OFF      12'h000
`define FSW_DATA_OFF     12'h004
`define FSW_STAT_OFF     12'h008
`define FSW_CTRL_OFF     12'h00c
// command opcode low six bits
`define FSW_OP_WRITE     6'h05
`define FSW_OP_WRITE_DEL 6'h09
// status field positions
`define FSW_IC_HI        7
`define FSW_IC_LO        6
`define FSW_S1_EOT       7
`define FSW_S1_CRC       5
`define FSW_S1_OVR       4
`define FSW_S1_WP        1
// interrupt code values
`define FSW_IC_NORMAL    2'h0
`define FSW_IC_ABNORMAL  2'h1
// counts
`define FSW_CMD_BYTES    4'h9
`define FSW_RES_BYTES    3'h7
`define FSW_GAP2_CONV    8'h16
`define FSW_GAP2_PERP    8'h08
`define FSW_PREAMBLE     8'h0c
`define FSW_SEEK_CYC     8'h20
// time allowed for the host to supply a byte, in ns, and derived cycles
`define FSW_BYTE_NS      1600
`define FSW_CLK_NS       100
`define FSW_BYTE_CYC     (`FSW_BYTE_NS / `FSW_CLK_NS)
// address marks
`define FSW_MARK_DATA    8'hfb
`define FSW_MARK_DEL     8'hf8
`define FSW_PRE_BYTE     8'h00
`endif

// [common/fsw_pkg.sv]
package fsw_pkg;
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0000,
		ST_CMD    = 4'b0001,
		ST_SEEK   = 4'b0010,
		ST_SEARCH = 4'b0011,
		ST_GAP    = 4'b0100,
		ST_PRE    = 4'b0101,
		ST_MARK   = 4'b0110,
		ST_DATA   = 4'b0111,
		ST_RESULT = 4'b1000
	} fsw_state_t;
	typedef logic [7:0] fsw_byte_t;
endpackage

// [design/fsw_apb.sv]
`include "fsw_regs.svh"
// apb slave: zero wait states, decodes four word registers
module fsw_apb (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	output logic             wr_cmd,
	output logic             wr_data,
	output logic             wr_ctrl,
	output logic             rd_data,
	output logic [7:0]       wbyte,
	input  wire logic [7:0]  res_byte,
	input  wire logic [7:0]  stat_byte,
	input  wire logic [7:0]  ctrl_byte
);
	logic        acc;
	logic        hit;
	logic [31:0] rmux;
	// access phase strobes
	assign acc     = psel & penable;
	assign pready  = 1'b1;
	assign hit     = (paddr == `FSW_CMD_OFF) | (paddr == `FSW_DATA_OFF) |
	                 (paddr == `FSW_STAT_OFF) | (paddr == `FSW_CTRL_OFF);
	assign pslverr = acc & ~hit;
	assign wr_cmd  = acc & pwrite & (paddr == `FSW_CMD_OFF);
	assign wr_data = acc & pwrite & (paddr == `FSW_DATA_OFF);
	assign wr_ctrl = acc & pwrite & (paddr == `FSW_CTRL_OFF);
	assign rd_data = acc & ~pwrite & (paddr == `FSW_DATA_OFF);
	assign wbyte   = pwdata[7:0];
	// read mux, unmapped reads return zero
	always_comb begin
		case (paddr)
			`FSW_DATA_OFF: rmux = {24'h000000, res_byte};
			`FSW_STAT_OFF: rmux = {24'h000000, stat_byte};
			`FSW_CTRL_OFF: rmux = {24'h000000, ctrl_byte};
			default:       rmux = 32'h00000000;
		endcase
	end
	// registered read data, loaded in setup so it is valid at access
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
		end else begin
			prdata <= (psel & ~penable & ~pwrite) ? rmux : prdata;
		end
	end
endmodule

// [design/fsw_serial.sv]
`include "fsw_regs.svh"
// byte to disk bit shifter, msb first, one bit per clock
module fsw_serial (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       load,
	input  wire logic [7:0] din,
	output logic            busy,
	output logic            wr_bit,
	output logic            wr_gate
);
	logic [7:0] sh;
	logic [3:0] cnt;
	logic [7:0] next_sh;
	logic [3:0] next_cnt;
	// shift control
	always_comb begin
		next_sh  = sh;
		next_cnt = cnt;
		if (load) begin
			next_sh  = din;
			next_cnt = 4'h8;
		end else if (cnt != 4'h0) begin
			next_sh  = {sh[6:0], 1'b0};
			next_cnt = cnt - 4'h1;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sh  <= 8'h00;
			cnt <= 4'h0;
		end else begin
			sh  <= next_sh;
			cnt <= next_cnt;
		end
	end
	assign busy    = (cnt > 4'h1);
	assign wr_bit  = sh[7] & (cnt != 4'h0);
	assign wr_gate = (cnt != 4'h0);
endmodule

// [design/fsw_core.sv]
// Overview of operation
// - address field crc error ends command abnormally, sets crc flag bit 5
// - active write protect sets bit 1, ends command without writing
// - wait whole gap 2 conventional, part of it perpendicular
// - write preamble, then address mark, then data bytes
// - after a sector, continue with next sector unless terminated
// - terminal count stops transfer with interrupt code 00
// - sector equal end of track sets bit 7, code 01
// - late host byte sets overrun bit 4, code 01, ends command
// - on overrun, rest of field repeats last good byte
// - multi track continues on side 1 after side 0 last sector
// - end of execution raises interrupt line for result phase
// - after error, result id names sector being processed
// - opcode 001001 writes deleted address mark, otherwise identical
// - deleted write data comes by dma or programmed transfers
// - opcode 000101 writes normal data address mark
// - implied seek bit makes controller seek itself first
// - two index pulses with no match end command abnormally
`include "fsw_regs.svh"
module fsw_core
	import fsw_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	input  wire logic        dma_ack,
	input  wire logic        terminal_count,
	output logic             dma_req,
	input  wire logic        id_valid,
	input  wire logic [7:0]  id_track,
	input  wire logic [7:0]  id_head,
	input  wire logic [7:0]  id_sector,
	input  wire logic [7:0]  id_size,
	input  wire logic        id_crc_err,
	input  wire logic        index_pulse,
	input  wire logic        write_protect,
	input  wire logic        seek_done,
	output logic             seek_start,
	output logic             head_side,
	output logic             wr_bit,
	output logic             wr_gate,
	output logic             irq
);
	import fsw_pkg::*;

	logic        wr_cmd;
	logic        wr_data;
	logic        wr_ctrl;
	logic        rd_data;
	logic [7:0]  wbyte;
	logic [7:0]  res_byte;
	logic [7:0]  stat_byte;
	logic [7:0]  ctrl;
	logic        ser_busy;
	logic        ser_load;
	fsw_byte_t   ser_din;

	fsw_state_t  state;
	fsw_state_t  next_state;
	fsw_byte_t   cmd [0:8];
	fsw_byte_t   next_cmd [0:8];
	logic [3:0]  bcnt;
	logic [3:0]  next_bcnt;
	logic [15:0] dcnt;
	logic [15:0] next_dcnt;
	logic [7:0]  tmr;
	logic [7:0]  next_tmr;
	logic [1:0]  idx;
	logic [1:0]  next_idx;
	fsw_byte_t   last;
	fsw_byte_t   next_last;
	logic        have;
	logic        next_have;
	fsw_byte_t   st0;
	fsw_byte_t   next_st0;
	fsw_byte_t   st1;
	fsw_byte_t   next_st1;
	logic        ovr;
	logic        next_ovr;
	logic        stop_tc;
	logic        next_stop_tc;
	logic        irq_q;
	logic        next_irq;

	logic        deleted;
	logic        perp;
	logic        match;
	logic        host_byte;
	logic [15:0] sec_len;

	fsw_apb u_apb (
		.clock     (clock),
		.rst_n     (rst_n),
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.pready    (pready),
		.pslverr   (pslverr),
		.prdata    (prdata),
		.wr_cmd    (wr_cmd),
		.wr_data   (wr_data),
		.wr_ctrl   (wr_ctrl),
		.rd_data   (rd_data),
		.wbyte     (wbyte),
		.res_byte  (res_byte),
		.stat_byte (stat_byte),
		.ctrl_byte (ctrl)
	);

	fsw_serial u_ser (
		.clock   (clock),
		.rst_n   (rst_n),
		.load    (ser_load),
		.din     (ser_din),
		.busy    (ser_busy),
		.wr_bit  (wr_bit),
		.wr_gate (wr_gate)
	);

	// decoded command fields
	// deleted mark select
	assign deleted   = (cmd[0][5:0] == `FSW_OP_WRITE_DEL);
	assign perp      = ctrl[0];
	assign head_side = cmd[3][0];
	assign sec_len   = 16'h0080 << cmd[5][2:0];
	assign match     = (id_track == cmd[2]) & (id_head == cmd[3]) &
	                   (id_sector == cmd[4]) & (id_size == cmd[5]);
	// byte from dma or programmed write
	assign host_byte = (dma_ack | wr_data) & (state == ST_DATA) & ~have;
	assign dma_req   = (state == ST_DATA) & ~have & ~ovr & ~ctrl[1];
	assign irq       = irq_q;
	assign stat_byte = {state == ST_RESULT, state != ST_IDLE, 2'h0, state};
	always_comb begin
		case (bcnt)
			4'h0:    res_byte = st0;
			4'h1:    res_byte = st1;
			4'h2:    res_byte = 8'h00;
			4'h3:    res_byte = cmd[2];
			4'h4:    res_byte = cmd[3];
			4'h5:    res_byte = cmd[4];
			4'h6:    res_byte = cmd[5];
			default: res_byte = 8'h00;
		endcase
	end

	// control register, bit0 perpendicular, bit1 programmed mode
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= 8'h00;
		end else begin
			ctrl <= wr_ctrl ? {6'h00, wbyte[1:0]} : ctrl;
		end
	end

	// sequencer next state
	always_comb begin
		next_state   = state;
		next_cmd     = cmd;
		next_bcnt    = bcnt;
		next_dcnt    = dcnt;
		next_tmr     = tmr;
		next_idx     = idx;
		next_last    = last;
		next_have    = have;
		next_st0     = st0;
		next_st1     = st1;
		next_ovr     = ovr;
		next_stop_tc = stop_tc | (terminal_count & (state == ST_DATA));
		next_irq     = irq_q;
		ser_load     = 1'b0;
		ser_din      = last;
		seek_start   = 1'b0;
		if (host_byte) begin
			next_last = (dma_ack ? pwdata[7:0] : wbyte);
			next_have = 1'b1;
		end
		case (state)
			ST_IDLE: begin
				if (wr_cmd) begin
					next_cmd[0] = wbyte;
					next_bcnt   = 4'h1;
					next_state  = ST_CMD;
				end
			end
			ST_CMD: begin
				if (wr_cmd) begin
					next_cmd[bcnt] = wbyte;
					next_bcnt      = bcnt + 4'h1;
					if (bcnt == `FSW_CMD_BYTES - 4'h1) begin
						next_st0 = {2'h0, 3'h0, cmd[1][2:0]};
						next_st1 = 8'h00;
						next_ovr = 1'b0;
						next_stop_tc = 1'b0;
						next_idx = 2'h0;
						next_tmr = `FSW_SEEK_CYC;
						if (cmd[0][5:0] != `FSW_OP_WRITE && cmd[0][5:0] != `FSW_OP_WRITE_DEL) begin
							next_st0[`FSW_IC_HI:`FSW_IC_LO] = 2'h2;
							next_state = ST_RESULT;
						end else if (write_protect) begin
							next_st1[`FSW_S1_WP] = 1'b1;
							next_st0[`FSW_IC_HI:`FSW_IC_LO] = `FSW_IC_ABNORMAL;
							next_state = ST_RESULT;
						end else if (cmd[1][7]) begin
							next_state = ST_SEEK;
						end else begin
							next_state = ST_SEARCH;
						end
					end
				end
			end
			ST_SEEK: begin
				seek_start = (tmr == `FSW_SEEK_CYC);
				next_tmr   = (tmr != 8'h00) ? tmr - 8'h01 : tmr;
				if (seek_done) begin
					next_state = ST_SEARCH;
				end
			end
			ST_SEARCH: begin
				next_idx = idx + {1'b0, index_pulse & (idx != 2'h2)};
				if (wr_data) begin
					next_st0[`FSW_IC_HI:`FSW_IC_LO] = `FSW_IC_ABNORMAL;
					next_state = ST_RESULT;
				end else if (id_valid & id_crc_err) begin
					next_st1[`FSW_S1_CRC] = 1'b1;
					next_st0[`FSW_IC_HI:`FSW_IC_LO] = `FSW_IC_ABNORMAL;
					next_state = ST_RESULT;
				end else if (id_valid & match) begin
					// gap 2 length by drive mode
					next_tmr   = perp ? `FSW_GAP2_PERP : `FSW_GAP2_CONV;
					next_state = ST_GAP;
				end else if (idx == 2'h2) begin
					next_st0[`FSW_IC_HI:`FSW_IC_LO] = `FSW_IC_ABNORMAL;
					next_state = ST_RESULT;
				end
			end
			ST_GAP: begin
				next_tmr = tmr - 8'h01;
				if (tmr == 8'h01) begin
					next_tmr   = `FSW_PREAMBLE;
					next_state = ST_PRE;
				end
			end
			ST_PRE: begin
				if (!ser_busy) begin
					ser_load = 1'b1;
					ser_din  = `FSW_PRE_BYTE;
					next_tmr = tmr - 8'h01;
					if (tmr == 8'h01) begin
						next_state = ST_MARK;
					end
				end
			end
			ST_MARK: begin
				if (!ser_busy) begin
					ser_load   = 1'b1;
					ser_din    = deleted ? `FSW_MARK_DEL : `FSW_MARK_DATA;
					next_dcnt  = sec_len;
					next_tmr   = 8'(`FSW_BYTE_CYC);
					next_state = ST_DATA;
				end
			end
			ST_DATA: begin
				next_tmr = (tmr != 8'h00) ? tmr - 8'h01 : tmr;
				if (!have && !ovr && tmr == 8'h00) begin
					next_ovr = 1'b1;
					next_st1[`FSW_S1_OVR] = 1'b1;
					next_st0[`FSW_IC_HI:`FSW_IC_LO] = `FSW_IC_ABNORMAL;
				end
				if (!ser_busy && (have || ovr)) begin
					ser_load  = 1'b1;
					ser_din   = last;
					next_have = host_byte;
					next_tmr  = 8'(`FSW_BYTE_CYC);
					next_dcnt = dcnt - 16'h0001;
					if (dcnt == 16'h0001) begin
						next_tmr = 8'h08;
						if (ovr) begin
							next_state = ST_RESULT;
						end else if (stop_tc | terminal_count) begin
							next_st0[`FSW_IC_HI:`FSW_IC_LO] = `FSW_IC_NORMAL;
							next_state = ST_RESULT;
						end else if (cmd[4] == cmd[6] && (!cmd[0][7] || cmd[3][0])) begin
							next_st1[`FSW_S1_EOT] = 1'b1;
							next_st0[`FSW_IC_HI:`FSW_IC_LO] = `FSW_IC_ABNORMAL;
							next_state = ST_RESULT;
						end else if (cmd[4] == cmd[6]) begin
							next_cmd[3] = cmd[3] | 8'h01;
							next_cmd[1] = cmd[1] | 8'h04;
							next_cmd[4] = 8'h01;
							next_idx    = 2'h0;
							next_state  = ST_SEARCH;
						end else begin
							next_cmd[4] = cmd[4] + 8'h01;
							next_idx    = 2'h0;
							next_state  = ST_SEARCH;
						end
					end
				end
			end
			ST_RESULT: begin
				if (rd_data) begin
					next_bcnt = bcnt + 4'h1;
					if (bcnt == {1'b0, `FSW_RES_BYTES} - 4'h1) begin
						next_irq   = 1'b0;
						next_state = ST_IDLE;
					end
				end
			end
			default: next_state = ST_IDLE;
		endcase
		if (next_state == ST_RESULT && state != ST_RESULT) begin
			next_irq  = 1'b1;
			next_bcnt = 4'h0;
		end
	end

	// sequencer registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state   <= ST_IDLE;
			cmd     <= '{default: 8'h00};
			bcnt    <= 4'h0;
			dcnt    <= 16'h0000;
			tmr     <= 8'h00;
			idx     <= 2'h0;
			last    <= 8'h00;
			have    <= 1'b0;
			st0     <= 8'h00;
			st1     <= 8'h00;
			ovr     <= 1'b0;
			stop_tc <= 1'b0;
			irq_q   <= 1'b0;
		end else begin
			state   <= next_state;
			cmd     <= next_cmd;
			bcnt    <= next_bcnt;
			dcnt    <= next_dcnt;
			tmr     <= next_tmr;
			idx     <= next_idx;
			last    <= next_last;
			have    <= next_have;
			st0     <= next_st0;
			st1     <= next_st1;
			ovr     <= next_ovr;
			stop_tc <= next_stop_tc;
			irq_q   <= next_irq;
		end
	end
endmodule

// [bench/fsw_core_checker.sv]
module fsw_core_checker (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	input wire logic        dma_req,
	input wire logic        write_protect,
	input wire logic        id_valid,
	input wire logic        seek_start,
	input wire logic        wr_bit,
	input wire logic        wr_gate,
	input wire logic        irq
);
	logic       acc;
	logic       bad;
	logic       rd_res;
	logic [2:0] n_rd;
	logic [2:0] next_n_rd;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// access decode
	assign acc = psel && penable;
	assign bad = !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c});
	assign rd_res = acc && !pwrite && paddr == 12'h004;
	// result reads while the interrupt stands
	always_comb begin
		next_n_rd = n_rd;
		if (!irq)
			next_n_rd = 3'h0;
		else if (rd_res)
			next_n_rd = n_rd + 3'h1;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			n_rd <= 3'h0;
		else
			n_rd <= next_n_rd;
	end
	sequence s_gap;
		!wr_gate [*7];
	endsequence
	sequence s_pre;
		!wr_bit [*8];
	endsequence
	chk_ready_high: assert property (pready) else $error("pready low");
	chk_bad_err: assert property (acc && bad |-> pslverr) else $error("no slave error");
	chk_good_ok: assert property (acc && !bad |-> !pslverr) else $error("false slave error");
	chk_bad_zero: assert property (acc && bad && !pwrite |-> prdata == 32'h0) else $error("bad read data");
	chk_wp_no_gate: assert property (write_protect |-> !$rose(wr_gate)) else $error("wrote protected");
	chk_gap_wait: assert property (id_valid && !wr_gate |=> s_gap) else $error("gap cut");
	chk_pre_zero: assert property ($rose(wr_gate) && !$past(dma_req, 2) |-> s_pre) else $error("preamble bits");
	chk_req_in_gate: assert property ($rose(dma_req) |-> wr_gate) else $error("request off field");
	chk_irq_end: assert property ($rose(irq) |-> !dma_req ##8 !wr_gate) else $error("irq in exec");
	chk_irq_clear: assert property (rd_res && irq && n_rd == 3'h6 |=> !irq) else $error("irq stuck");
	chk_seek_first: assert property (seek_start |=> !wr_gate [*8]) else $error("write in seek");
endmodule
bind fsw_core fsw_core_checker i_fsw_core_checker (
	.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pready(pready), .pslverr(pslverr), .prdata(prdata), .dma_req(dma_req), .write_protect(write_protect),
	.id_valid(id_valid), .seek_start(seek_start), .wr_bit(wr_bit), .wr_gate(wr_gate), .irq(irq)
);

// [bench/fsw_drive_model.sv]
module fsw_drive_model #(
	parameter logic [7:0] TRACK   = 8'h05,
	parameter logic [7:0] SECTORS = 8'h03
) (
	input  wire logic  clock,
	input  wire logic  wr_gate,
	input  wire logic  seek_start,
	input  wire logic  head_side,
	input  wire logic  crc_en,
	input  wire logic  no_disk,
	output logic       id_valid,
	output logic [7:0] id_track,
	output logic [7:0] id_head,
	output logic [7:0] id_sector,
	output logic [7:0] id_size,
	output logic       id_crc_err,
	output logic       index_pulse,
	output logic       seek_done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] slot;
	logic [7:0] wait_cnt;
	// one id field or index mark each 41 clocks, none while writing
	initial begin
		{id_valid, id_crc_err, index_pulse, seek_done} = 4'h0;
		{id_track, id_head, id_sector, id_size} = 32'hffffffff;
		slot = 8'h00;
		wait_cnt = 8'h00;
		forever begin
			repeat (40) @(posedge clock);
			while (wr_gate === 1'b1) @(posedge clock);
			if (slot == SECTORS) begin
				index_pulse <= 1'b1;
				slot = 8'h00;
			end else begin
				id_valid <= !no_disk;
				id_crc_err <= crc_en;
				{id_track, id_head, id_sector, id_size} <= {TRACK, 7'h00, head_side, slot + 8'h01, 8'h00};
				slot = slot + 8'h01;
			end
			@(posedge clock);
			{id_valid, index_pulse, id_crc_err} <= 3'h0;
			// released id lines flip
			{id_track, id_head, id_sector, id_size} <= ~{id_track, id_head, id_sector, id_size};
		end
	end
	// slow seek, 30 clocks
	always @(posedge clock) begin
		seek_done <= (wait_cnt == 8'h01);
		if (seek_start === 1'b1)
			wait_cnt <= 8'h1e;
		else if (wait_cnt != 8'h00)
			wait_cnt <= wait_cnt - 8'h01;
	end
endmodule

// [bench/tb_top.sv]
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] TRK = 8'h05;
	logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, dma_ack, terminal_count, dma_req;
	logic        id_valid, id_crc_err, index_pulse, write_protect, seek_done, seek_start, head_side;
	logic        wr_bit, wr_gate, irq, crc_en, no_disk;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [7:0]  id_track, id_head, id_sector, id_size, dbyte, sh;
	logic [15:0] n_sent, lim;
	logic        e;
	logic [7:0]  disk_q[$];
	int          n_mismatch, n_compared, n_seek, nb;
	fsw_core i_fsw_core (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.dma_ack(dma_ack), .terminal_count(terminal_count), .dma_req(dma_req), .id_valid(id_valid),
		.id_track(id_track), .id_head(id_head), .id_sector(id_sector), .id_size(id_size),
		.id_crc_err(id_crc_err), .index_pulse(index_pulse), .write_protect(write_protect),
		.seek_done(seek_done), .seek_start(seek_start), .head_side(head_side), .wr_bit(wr_bit),
		.wr_gate(wr_gate), .irq(irq));
	fsw_drive_model #(.TRACK(TRK), .SECTORS(8'h03)) i_fsw_drive_model (.clock(clock), .wr_gate(wr_gate),
		.seek_start(seek_start), .head_side(head_side), .crc_en(crc_en), .no_disk(no_disk),
		.id_valid(id_valid), .id_track(id_track), .id_head(id_head), .id_sector(id_sector),
		.id_size(id_size), .id_crc_err(id_crc_err), .index_pulse(index_pulse), .seek_done(seek_done));
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic start(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] sec, input logic [15:0] l);
		logic [7:0] b [9];
		b = '{op, b2, TRK, 8'h00, sec, 8'h00, 8'h03, 8'h1b, 8'hff};
		disk_q.delete();
		nb = 0;
		dbyte <= 8'h40;
		n_sent <= 16'h0;
		lim <= l;
		foreach (b[i]) apb(1'b1, 12'h000, {24'h0, b[i]});
	endtask
	task automatic res(input logic [1:0] ic, input logic [7:0] s1, input logic [7:0] sec, input logic [7:0] hd = 8'h00);
		logic [7:0] x [7];
		int i;
		x = '{{ic, 6'h00}, s1, 8'h00, TRK, hd, sec, 8'h00};
		i = 0;
		while (irq !== 1'b1 && i < 20000) begin
			@(posedge clock);
			i++;
		end
		chk("irq", {31'h0, irq}, 32'h1);
		for (i = 0; i < 7; i++) begin
			apb(1'b0, 12'h004, 32'h0);
			chk("result", {24'h0, q[7:0]}, {24'h0, x[i]});
		end
		@(posedge clock);
		chk("irq off", {31'h0, irq}, 32'h0);
	endtask
	always @(posedge clock) begin
		if (dma_ack)
			dma_ack <= 1'b0;
		else if (dma_req === 1'b1 && n_sent != lim) begin
			dma_ack <= 1'b1;
			pwdata <= {24'h0, dbyte};
			dbyte <= dbyte + 8'h01;
			n_sent <= n_sent + 16'h1;
		end
	end
	// disk bytes, msb first, and seek count
	always @(posedge clock) begin
		if (seek_start === 1'b1)
			n_seek = n_seek + 1;
		if (wr_gate === 1'b1) begin
			sh = {sh[6:0], wr_bit};
			nb = nb + 1;
			if (nb % 8 == 0)
				disk_q.push_back(sh);
		end
	end
	initial begin
		#4000000;
		n_mismatch++;
		print_verdict();
	end
	initial begin
		{rst_n, psel, penable, pwrite, dma_ack, terminal_count, write_protect, crc_en, no_disk} = '0;
		{paddr, pwdata, dbyte, n_sent, lim, n_seek, nb} = '0;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		apb(1'b0, 12'h010, 32'h0);
		chk("bad err", {31'h0, e}, 32'h1);
		chk("bad data", q, 32'h0);
		apb(1'b1, 12'h00c, 32'h0);
		start(8'h46, 8'h00, 8'h01, 16'hffff);
		res(2'h2, 8'h00, 8'h01);
		write_protect <= 1'b1;
		start(8'h45, 8'h00, 8'h01, 16'hffff);
		res(2'h1, 8'h02, 8'h01);
		chk("no write", disk_q.size(), 32'h0);
		write_protect <= 1'b0;
		crc_en <= 1'b1;
		start(8'h45, 8'h00, 8'h01, 16'hffff);
		res(2'h1, 8'h20, 8'h01);
		crc_en <= 1'b0;
		start(8'h45, 8'h00, 8'h02, 16'hffff);
		res(2'h1, 8'h80, 8'h03);
		chk("mark", {24'h0, disk_q[12]}, 32'h000000fb);
		chk("data", {24'h0, disk_q[13]}, 32'h00000040);
		chk("next mark", {24'h0, disk_q[153]}, 32'h000000fb);
		start(8'hc5, 8'h00, 8'h03, 16'hffff);
		res(2'h1, 8'h80, 8'h03, 8'h01);
		apb(1'b1, 12'h00c, 32'h1);
		apb(1'b0, 12'h00c, 32'h0);
		chk("ctrl", q, 32'h1);
		terminal_count <= 1'b1;
		start(8'h49, 8'h00, 8'h01, 16'hffff);
		res(2'h0, 8'h00, 8'h01);
		chk("del mark", {24'h0, disk_q[12]}, 32'h000000f8);
		chk("del data", {24'h0, disk_q[13]}, 32'h00000040);
		terminal_count <= 1'b0;
		start(8'h45, 8'h00, 8'h01, 16'h0005);
		res(2'h1, 8'h10, 8'h01);
		chk("repeat", {24'h0, disk_q[140]}, 32'h00000044);
		no_disk <= 1'b1;
		start(8'h45, 8'h80, 8'h01, 16'hffff);
		res(2'h1, 8'h00, 8'h01);
		chk("seeks", n_seek, 32'h1);
		start(8'h45, 8'h00, 8'h01, 16'hffff);
		apb(1'b1, 12'h004, 32'h0);
		res(2'h1, 8'h00, 8'h01);
		print_verdict();
	end
endmodule
